// >>> core/msp_doze.sv
`timescale 1ns/1ps
module msp_doze #(
  parameter logic [35:0] DOWN1 = msp_pkg::DOWNSHIFT1_CYCLES,
  parameter logic [35:0] DOWN2 = msp_pkg::DOWNSHIFT2_CYCLES,
  parameter logic [35:0] DOWN3 = msp_pkg::DOWNSHIFT3_CYCLES,
  parameter logic [35:0] RESP1 = msp_pkg::RESPONSE1_CYCLES,
  parameter logic [35:0] RESP2 = msp_pkg::RESPONSE2_CYCLES,
  parameter logic [35:0] RESP3 = msp_pkg::RESPONSE3_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic motionSeen,
  output logic frameTick,
  output logic [1:0] dozeLevel
);

  msp_pkg::msp_doze_e stateReg;
  logic [35:0] idleCntReg;
  logic [35:0] frameCntReg;
  logic frameDue;
  logic downDue;

  function automatic logic [35:0] framePeriod(msp_pkg::msp_doze_e s);
    unique case (s)
      msp_pkg::DOZE_RUN: framePeriod = msp_pkg::RUN_FRAME_CYCLES;
      msp_pkg::DOZE_L1: framePeriod = RESP1;
      msp_pkg::DOZE_L2: framePeriod = RESP2;
      msp_pkg::DOZE_L3: framePeriod = RESP3;
    endcase
  endfunction

  function automatic logic [35:0] dwellLimit(msp_pkg::msp_doze_e s);
    unique case (s)
      msp_pkg::DOZE_RUN: dwellLimit = DOWN1;
      msp_pkg::DOZE_L1: dwellLimit = DOWN2;
      msp_pkg::DOZE_L2: dwellLimit = DOWN3;
      msp_pkg::DOZE_L3: dwellLimit = DOWN3;
    endcase
  endfunction

  assign frameDue = (frameCntReg >= framePeriod(stateReg) - 36'h000000001);
  assign downDue = (idleCntReg >= dwellLimit(stateReg) - 36'h000000001);

  // ---------------------------------------------------------------
  // Level stepping
  // ---------------------------------------------------------------
  // timed doze downshift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateReg <= msp_pkg::DOZE_RUN;
      idleCntReg <= 36'h000000000;
    end else if (motionSeen) begin
      stateReg <= msp_pkg::DOZE_RUN;
      idleCntReg <= 36'h000000000;
    end else if (stateReg != msp_pkg::DOZE_L3) begin
      if (downDue) begin
        idleCntReg <= 36'h000000000;
        unique case (stateReg)
          msp_pkg::DOZE_RUN: stateReg <= msp_pkg::DOZE_L1;
          msp_pkg::DOZE_L1: stateReg <= msp_pkg::DOZE_L2;
          msp_pkg::DOZE_L2: stateReg <= msp_pkg::DOZE_L3;
          msp_pkg::DOZE_L3: stateReg <= msp_pkg::DOZE_L3;
        endcase
      end else begin
        idleCntReg <= idleCntReg + 36'h000000001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame pacing
  // ---------------------------------------------------------------
  // per-level detection period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameCntReg <= 36'h000000000;
      frameTick <= 1'b0;
    end else begin
      frameTick <= frameDue;
      if (frameDue || (motionSeen && stateReg != msp_pkg::DOZE_RUN)) begin
        frameCntReg <= 36'h000000000;
      end else begin
        frameCntReg <= frameCntReg + 36'h000000001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dozeLevel <= 2'h0;
    end else begin
      unique case (stateReg)
        msp_pkg::DOZE_RUN: dozeLevel <= 2'h0;
        msp_pkg::DOZE_L1: dozeLevel <= 2'h1;
        msp_pkg::DOZE_L2: dozeLevel <= 2'h2;
        msp_pkg::DOZE_L3: dozeLevel <= 2'h3;
      endcase
    end
  end

endmodule

// >>> core/msp_serial_port.sv
`timescale 1ns/1ps
module msp_serial_port #(
  parameter logic [35:0] DOWN1 = msp_pkg::DOWNSHIFT1_CYCLES,
  parameter logic [35:0] DOWN2 = msp_pkg::DOWNSHIFT2_CYCLES,
  parameter logic [35:0] DOWN3 = msp_pkg::DOWNSHIFT3_CYCLES,
  parameter logic [35:0] RESP1 = msp_pkg::RESPONSE1_CYCLES,
  parameter logic [35:0] RESP2 = msp_pkg::RESPONSE2_CYCLES,
  parameter logic [35:0] RESP3 = msp_pkg::RESPONSE3_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spiSclk,
  input wire logic spiMosi,
  input wire logic port_select_n,
  output logic spiMiso,
  output logic spiMisoOe,
  output logic motionPendingN,
  output logic illum_led_drive,
  output logic imageRequest,
  output logic [1:0] dozeLevel,
  input wire logic navFrameValid,
  input wire logic [7:0] navDeltaX,
  input wire logic [7:0] navDeltaY,
  input wire logic [7:0] navSqual,
  input wire logic [15:0] navShutter,
  input wire logic [7:0] navMaxPixel
);

  // ---------------------------------------------------------------
  // Link-side declarations
  // ---------------------------------------------------------------
  logic linkRst, rdTglReg, wrTglReg, misoReg;
  msp_pkg::msp_link_e linkStateReg;
  logic [2:0] bitCntReg, burstIdxReg;
  logic [6:0] shiftInReg, reqAddrReg;
  logic [7:0] wrDataReg, inByte, outByte;

  // ---------------------------------------------------------------
  // Core-side declarations
  // ---------------------------------------------------------------
  logic rdTglSync, wrTglSync, rdTglSeenReg, wrTglSeenReg, rdEvent, wrEvent;
  logic motionReg, seenDyReg, seenDxReg, navMotion, readDy, readDx, motionClear, frameTick;
  logic [7:0] dyReg, dxReg, squalReg, maxPixReg, configReg, rdDataReg, ledCntReg;
  logic [15:0] shutterReg;
  logic [55:0] burstReg;

  function automatic logic [7:0] burstByte(input logic [55:0] word, input logic [2:0] idx);
    burstByte = word[8'(55) - 8'({idx, 3'h0}) -: 8];
  endfunction

  function automatic logic isAddr(input logic [6:0] addr, input logic [6:0] want);
    isAddr = (addr == want);
  endfunction

  // port held reset while select high
  assign linkRst = sys_rst | port_select_n;
  assign inByte = {shiftInReg, spiMosi};

  // ---------------------------------------------------------------
  // Link receive state, rising serial clock
  // ---------------------------------------------------------------
  // port wakes on select low
  always_ff @(posedge spiSclk or posedge linkRst) begin
    if (linkRst) begin
      linkStateReg <= msp_pkg::LINK_ADDR;
      bitCntReg <= 3'h0;
      shiftInReg <= 7'h00;
      burstIdxReg <= 3'h0;
    end else begin
      shiftInReg <= inByte[6:0];
      if (linkStateReg != msp_pkg::LINK_DONE) begin
        bitCntReg <= bitCntReg + 3'h1;
      end
      if (bitCntReg == msp_pkg::BIT_LAST) begin
        unique case (linkStateReg)
          msp_pkg::LINK_ADDR: begin
            // top bit one marks a write
            // top bit zero marks a read
            if (inByte[msp_pkg::DIR_BIT]) begin
              linkStateReg <= msp_pkg::LINK_WDATA;
            end else if (isAddr(inByte[6:0], msp_pkg::ADDR_BURST)) begin
              linkStateReg <= msp_pkg::LINK_BURST;
            end else begin
              linkStateReg <= msp_pkg::LINK_RDATA;
            end
          end
          msp_pkg::LINK_WDATA: linkStateReg <= msp_pkg::LINK_ADDR;
          msp_pkg::LINK_RDATA: linkStateReg <= msp_pkg::LINK_ADDR;
          msp_pkg::LINK_BURST: begin
            burstIdxReg <= burstIdxReg + 3'h1;
            if (burstIdxReg == msp_pkg::BURST_LAST) begin
              linkStateReg <= msp_pkg::LINK_DONE;
            end
          end
          msp_pkg::LINK_DONE: linkStateReg <= msp_pkg::LINK_DONE;
        endcase
      end
    end
  end

  // Request words and toggles survive select so no false event appears
  always_ff @(posedge spiSclk or posedge sys_rst) begin
    if (sys_rst) begin
      reqAddrReg <= 7'h00;
      wrDataReg <= 8'h00;
      rdTglReg <= 1'b0;
      wrTglReg <= 1'b0;
    end else if (!port_select_n && bitCntReg == msp_pkg::BIT_LAST) begin
      if (linkStateReg == msp_pkg::LINK_ADDR) begin
        reqAddrReg <= inByte[6:0];
        if (!inByte[msp_pkg::DIR_BIT]) begin
          rdTglReg <= ~rdTglReg;
        end
      end else if (linkStateReg == msp_pkg::LINK_WDATA) begin
        wrDataReg <= inByte;
        wrTglReg <= ~wrTglReg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Link transmit, falling serial clock
  // ---------------------------------------------------------------
  // Read words are stable here: core loads them well inside the
  // address-to-data gap and holds them until the next request.
  assign outByte = (linkStateReg == msp_pkg::LINK_BURST) ?
                   burstByte(burstReg, burstIdxReg) : rdDataReg;

  always_ff @(negedge spiSclk or posedge linkRst) begin
    if (linkRst) begin
      misoReg <= 1'b0;
    end else if (linkStateReg == msp_pkg::LINK_RDATA ||
                 linkStateReg == msp_pkg::LINK_BURST) begin
      misoReg <= outByte[msp_pkg::BIT_LAST - bitCntReg];
    end
  end

  assign spiMiso = misoReg;
  assign spiMisoOe = !port_select_n &&
                     (linkStateReg == msp_pkg::LINK_RDATA ||
                      linkStateReg == msp_pkg::LINK_BURST);

  // ---------------------------------------------------------------
  // Request crossing into the core clock
  // ---------------------------------------------------------------
  msp_sync rdSync (.clk(core_clk), .rst(sys_rst), .asyncIn(rdTglReg), .syncOut(rdTglSync));
  msp_sync wrSync (.clk(core_clk), .rst(sys_rst), .asyncIn(wrTglReg), .syncOut(wrTglSync));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdTglSeenReg <= 1'b0;
      wrTglSeenReg <= 1'b0;
    end else begin
      rdTglSeenReg <= rdTglSync;
      wrTglSeenReg <= wrTglSync;
    end
  end

  assign rdEvent = rdTglSync ^ rdTglSeenReg;
  assign wrEvent = wrTglSync ^ wrTglSeenReg;

  // ---------------------------------------------------------------
  // Motion status and displacement
  // ---------------------------------------------------------------
  assign navMotion = navFrameValid && (navDeltaX != 8'h00 || navDeltaY != 8'h00);
  assign readDy = rdEvent && isAddr(reqAddrReg, msp_pkg::ADDR_DELTA_Y);
  assign readDx = rdEvent && isAddr(reqAddrReg, msp_pkg::ADDR_DELTA_X);

  // clear after both deltas, a burst read or a write to the motion register
  assign motionClear = (readDy && (seenDxReg || readDx)) ||
                       (readDx && (seenDyReg || readDy)) ||
                       (rdEvent && isAddr(reqAddrReg, msp_pkg::ADDR_BURST)) ||
                       (wrEvent && isAddr(reqAddrReg, msp_pkg::ADDR_MOTION));

  // New motion wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      motionReg <= 1'b0;
      seenDyReg <= 1'b0;
      seenDxReg <= 1'b0;
    end else begin
      if (navMotion) begin
        motionReg <= 1'b1;
      end else if (motionClear) begin
        motionReg <= 1'b0;
      end
      if (navMotion || motionClear) begin
        seenDyReg <= 1'b0;
        seenDxReg <= 1'b0;
      end else begin
        seenDyReg <= seenDyReg | readDy;
        seenDxReg <= seenDxReg | readDx;
      end
    end
  end

  // Deltas accumulate between reads and restart once read out
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dyReg <= 8'h00;
      dxReg <= 8'h00;
    end else begin
      dyReg <= ((readDy || (rdEvent && isAddr(reqAddrReg, msp_pkg::ADDR_BURST))) ?
                8'h00 : dyReg) + (navFrameValid ? navDeltaY : 8'h00);
      dxReg <= ((readDx || (rdEvent && isAddr(reqAddrReg, msp_pkg::ADDR_BURST))) ?
                8'h00 : dxReg) + (navFrameValid ? navDeltaX : 8'h00);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      squalReg <= 8'h00;
      shutterReg <= 16'h0000;
      maxPixReg <= 8'h00;
    end else if (navFrameValid) begin
      squalReg <= navSqual;
      shutterReg <= navShutter;
      maxPixReg <= navMaxPixel;
    end
  end

  assign motionPendingN = !motionReg;

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      configReg <= msp_pkg::CONFIG_RESET;
    end else if (wrEvent && isAddr(reqAddrReg, msp_pkg::ADDR_CONFIG)) begin
      configReg <= wrDataReg;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdDataReg <= 8'h00;
    end else if (rdEvent) begin
      unique case (reqAddrReg)
        msp_pkg::ADDR_MOTION: rdDataReg <= {motionReg, 7'h00};
        msp_pkg::ADDR_DELTA_Y: rdDataReg <= dyReg;
        msp_pkg::ADDR_DELTA_X: rdDataReg <= dxReg;
        msp_pkg::ADDR_SQUAL: rdDataReg <= squalReg;
        msp_pkg::ADDR_SHUT_HI: rdDataReg <= shutterReg[15:8];
        msp_pkg::ADDR_SHUT_LO: rdDataReg <= shutterReg[7:0];
        msp_pkg::ADDR_MAX_PIX: rdDataReg <= maxPixReg;
        msp_pkg::ADDR_CONFIG: rdDataReg <= configReg;
        default: rdDataReg <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      burstReg <= 56'h00000000000000;
    end else if (rdEvent && isAddr(reqAddrReg, msp_pkg::ADDR_BURST)) begin
      burstReg <= {motionReg, 7'h00, dyReg, dxReg, squalReg, shutterReg, maxPixReg};
    end
  end

  // ---------------------------------------------------------------
  // Power levels and illumination
  // ---------------------------------------------------------------
  msp_doze #(
    .DOWN1(DOWN1),
    .DOWN2(DOWN2),
    .DOWN3(DOWN3),
    .RESP1(RESP1),
    .RESP2(RESP2),
    .RESP3(RESP3)
  ) doze (
    .clk(core_clk),
    .rst(sys_rst),
    .motionSeen(navMotion),
    .frameTick(frameTick),
    .dozeLevel(dozeLevel)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ledCntReg <= 8'h00;
      illum_led_drive <= 1'b0;
      imageRequest <= 1'b0;
    end else begin
      imageRequest <= frameTick;
      if (frameTick) begin
        ledCntReg <= msp_pkg::LED_PULSE_CYCLES;
        illum_led_drive <= 1'b1;
      end else if (ledCntReg != 8'h00) begin
        ledCntReg <= ledCntReg - 8'h01;
        illum_led_drive <= (ledCntReg != 8'h01);
      end else begin
        illum_led_drive <= 1'b0;
      end
    end
  end

endmodule

// >>> core/msp_sync.sv
`timescale 1ns/1ps
module msp_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);

  logic stage1Reg;

  // ---------------------------------------------------------------
  // Two-stage level synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1Reg <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut <= stage1Reg;
    end
  end

endmodule

// >>> shared/msp_pkg.sv
package msp_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam longint CLK_MHZ = 64'd40;
  localparam longint DOWNSHIFT1_US = 64'd237000;
  localparam longint DOWNSHIFT2_US = 64'd8400000;
  localparam longint DOWNSHIFT3_US = 64'd504000000;
  localparam longint RESPONSE1_US = 64'd16500;
  localparam longint RESPONSE2_US = 64'd82000;
  localparam longint RESPONSE3_US = 64'd410000;
  localparam logic [35:0] DOWNSHIFT1_CYCLES = 36'(DOWNSHIFT1_US * CLK_MHZ);
  localparam logic [35:0] DOWNSHIFT2_CYCLES = 36'(DOWNSHIFT2_US * CLK_MHZ);
  localparam logic [35:0] DOWNSHIFT3_CYCLES = 36'(DOWNSHIFT3_US * CLK_MHZ);
  localparam logic [35:0] RESPONSE1_CYCLES = 36'(RESPONSE1_US * CLK_MHZ);
  localparam logic [35:0] RESPONSE2_CYCLES = 36'(RESPONSE2_US * CLK_MHZ);
  localparam logic [35:0] RESPONSE3_CYCLES = 36'(RESPONSE3_US * CLK_MHZ);
  localparam logic [35:0] RUN_FRAME_CYCLES = 36'h000000190;
  localparam logic [7:0] LED_PULSE_CYCLES = 8'h28;
  localparam int BURST_EXIT_GAP_NS = 500;

  // ---------------------------------------------------------------
  // Register addresses and fields
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_MOTION = 7'h02;
  localparam logic [6:0] ADDR_DELTA_Y = 7'h03;
  localparam logic [6:0] ADDR_DELTA_X = 7'h04;
  localparam logic [6:0] ADDR_SQUAL = 7'h05;
  localparam logic [6:0] ADDR_SHUT_HI = 7'h06;
  localparam logic [6:0] ADDR_SHUT_LO = 7'h07;
  localparam logic [6:0] ADDR_MAX_PIX = 7'h08;
  localparam logic [6:0] ADDR_CONFIG = 7'h11;
  localparam logic [6:0] ADDR_BURST = 7'h42;
  localparam int DIR_BIT = 7;
  localparam int MOTION_BIT = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h03;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BURST_LAST = 3'h6;

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    LINK_ADDR = 5'h01,
    LINK_WDATA = 5'h02,
    LINK_RDATA = 5'h04,
    LINK_BURST = 5'h08,
    LINK_DONE = 5'h10
  } msp_link_e;

  typedef enum logic [3:0] {
    DOZE_RUN = 4'h1,
    DOZE_L1 = 4'h2,
    DOZE_L2 = 4'h4,
    DOZE_L3 = 4'h8
  } msp_doze_e;

endpackage

// >>> verification/msp_host_model.sv
`timescale 1ns/1ps
module msp_host_model (
  output logic spiSclk,
  output logic spiMosi,
  output logic port_select_n,
  input wire logic misoWire
);
  logic [7:0] junk;
  initial begin
    spiSclk = 1'b1;
    spiMosi = 1'b0;
    port_select_n = 1'b1;
  end
  task automatic frame_open();
    port_select_n = 1'b0;
    #120;
  endtask
  task automatic frame_close(input int gapNs);
    #120;
    port_select_n = 1'b1;
    spiMosi = ~spiMosi;
    #(gapNs);
  endtask
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      spiSclk = 1'b0;
      spiMosi = tx[i];
      #7.5;
      spiSclk = 1'b1;
      rx[i] = misoWire;
      #7.5;
    end
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d, input int nb);
    frame_open();
    shift({1'b1, a}, 8, junk);
    shift(d, nb, junk);
    frame_close(30000);
  endtask
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    frame_open();
    shift({1'b0, a}, 8, junk);
    #4000;
    shift(8'h00, 8, d);
    frame_close(500);
  endtask
  task automatic burst(output logic [55:0] q);
    frame_open();
    shift({1'b0, msp_pkg::ADDR_BURST}, 8, junk);
    #4000;
    for (int k = 0; k < 7; k++) begin
      shift(8'h00, 8, junk);
      q[55 - 8 * k -: 8] = junk;
    end
  endtask
endmodule

// >>> verification/msp_serial_port_props.sv
`timescale 1ns/1ps
module msp_serial_port_props #(
  parameter logic [35:0] DOWN2 = 36'h1,
  parameter logic [35:0] DOWN3 = 36'h1,
  parameter logic [35:0] RESP1 = 36'h1,
  parameter logic [35:0] RESP2 = 36'h1,
  parameter logic [35:0] RESP3 = 36'h1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spiSclk,
  input wire logic port_select_n,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  input wire logic motionPendingN,
  input wire logic illum_led_drive,
  input wire logic imageRequest,
  input wire logic [1:0] dozeLevel,
  input wire logic navFrameValid,
  input wire logic [7:0] navDeltaX,
  input wire logic [7:0] navDeltaY
);
  // ----
  // Helper counters
  // ----
  logic [3:0] selHigh;
  logic [7:0] ledCnt, bitCnt;
  logic [35:0] gap, dwell, respNow, downNow;
  logic [1:0] lastLvl, lvlQ;
  logic misoAtRise, motion;
  assign motion = navFrameValid && (navDeltaX != 8'h00 || navDeltaY != 8'h00);
  assign respNow = dozeLevel == 2'd1 ? RESP1 : dozeLevel == 2'd2 ? RESP2 : RESP3;
  assign downNow = dozeLevel == 2'd2 ? DOWN2 : DOWN3;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      selHigh <= 4'h0;
      ledCnt <= 8'h00;
      lvlQ <= 2'h0;
      dwell <= 36'h0;
      gap <= 36'h0;
      lastLvl <= 2'h0;
    end else begin
      selHigh <= !port_select_n ? 4'h0 : selHigh + 4'(selHigh != 4'hf);
      ledCnt <= illum_led_drive ? ledCnt + 8'h01 : 8'h00;
      lvlQ <= dozeLevel;
      dwell <= dozeLevel != lvlQ ? 36'h1 : dwell + 36'h1;
      gap <= imageRequest ? 36'h1 : gap + 36'h1;
      lastLvl <= imageRequest ? dozeLevel : lastLvl;
    end
  end
  always_ff @(posedge spiSclk or posedge port_select_n) begin
    if (port_select_n) begin
      bitCnt <= 8'h00;
    end else begin
      bitCnt <= bitCnt + 8'(bitCnt != 8'hff);
    end
  end
  always_ff @(posedge spiSclk) begin
    misoAtRise <= spiMiso;
  end
  // ----
  // Properties
  // ----
  property p_float; @(posedge core_clk) disable iff (sys_rst)
    port_select_n |-> !spiMisoOe; endproperty
  a_float: assert property (p_float) else $error("output driven while deselected");
  property p_mot_set; @(posedge core_clk) disable iff (sys_rst)
    motion |=> !motionPendingN; endproperty
  a_mot_set: assert property (p_mot_set) else $error("motion pin not low");
  property p_mot_clr; @(posedge core_clk) disable iff (sys_rst)
    $rose(motionPendingN) |-> selHigh < 4'hc; endproperty
  a_mot_clr: assert property (p_mot_clr) else $error("motion pin rose unasked");
  property p_led; @(posedge core_clk) disable iff (sys_rst)
    $fell(illum_led_drive) |-> ledCnt == msp_pkg::LED_PULSE_CYCLES; endproperty
  a_led: assert property (p_led) else $error("led pulse width wrong");
  property p_rate; @(posedge core_clk) disable iff (sys_rst)
    imageRequest && dozeLevel != 2'd0 && dozeLevel == lastLvl
      |-> gap + 36'h1 >= respNow && gap <= respNow + 36'h1; endproperty
  a_rate: assert property (p_rate) else $error("doze frame period wrong");
  property p_dwell; @(posedge core_clk) disable iff (sys_rst)
    $changed(dozeLevel) && dozeLevel >= 2'd2
      |-> dwell + 36'h8 >= downNow && dwell <= downNow + 36'h8; endproperty
  a_dwell: assert property (p_dwell) else $error("downshift time wrong");
  property p_addr; @(posedge spiSclk) disable iff (port_select_n)
    bitCnt < 8'h08 |-> !spiMisoOe; endproperty
  a_addr: assert property (p_addr) else $error("output driven in address byte");
  property p_hold; @(negedge spiSclk) disable iff (port_select_n)
    spiMisoOe |-> spiMiso == misoAtRise; endproperty
  a_hold: assert property (p_hold) else $error("output bit moved in high phase");
  c_read: cover property (@(negedge spiSclk) spiMisoOe);
  c_led: cover property (@(posedge core_clk) $fell(illum_led_drive));
  c_deep: cover property (@(posedge core_clk) dozeLevel == 2'd3);
endmodule

bind msp_serial_port msp_serial_port_props #(.DOWN2(DOWN2), .DOWN3(DOWN3), .RESP1(RESP1),
  .RESP2(RESP2), .RESP3(RESP3)) chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .spiSclk(spiSclk), .port_select_n(port_select_n), .spiMiso(spiMiso),
  .spiMisoOe(spiMisoOe), .motionPendingN(motionPendingN), .illum_led_drive(illum_led_drive),
  .imageRequest(imageRequest), .dozeLevel(dozeLevel), .navFrameValid(navFrameValid),
  .navDeltaX(navDeltaX), .navDeltaY(navDeltaY));

// >>> verification/test_motion_sensor_serial_port.sv
`timescale 1ns/1ps
module test_motion_sensor_serial_port;
  localparam int D1 = 2000;
  localparam int D2 = 3000;
  localparam int D3 = 4000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic navFrameValid = 1'b0;
  logic spiSclk, spiMosi, port_select_n, spiMiso, spiMisoOe;
  logic motionPendingN, illum_led_drive, imageRequest;
  logic [1:0] dozeLevel;
  logic [7:0] dx = 8'h00, dy = 8'h00, sq = 8'h00, mp = 8'h00, rd;
  logic [15:0] sh = 16'h0000;
  logic [55:0] bd;
  wire misoWire = spiMisoOe ? spiMiso : 1'bz;
  int nFail = 0;
  int numChecks = 0;
  msp_serial_port #(.DOWN1(36'(D1)), .DOWN2(36'(D2)), .DOWN3(36'(D3)), .RESP1(36'h64),
    .RESP2(36'hc8), .RESP3(36'h12c)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .port_select_n(port_select_n), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .motionPendingN(motionPendingN), .illum_led_drive(illum_led_drive),
    .imageRequest(imageRequest), .dozeLevel(dozeLevel), .navFrameValid(navFrameValid),
    .navDeltaX(dx), .navDeltaY(dy), .navSqual(sq), .navShutter(sh), .navMaxPixel(mp));
  msp_host_model host (.spiSclk(spiSclk), .spiMosi(spiMosi), .port_select_n(port_select_n),
    .misoWire(misoWire));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    numChecks++;
    if (g !== e) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic nav(input logic [7:0] x, input logic [7:0] y);
    tick();
    navFrameValid = 1'b1;
    dx = x;
    dy = y;
    tick();
    navFrameValid = 1'b0;
    tick();
  endtask
  task automatic t_config();
    chk("pin", 8'h01, {7'h00, motionPendingN});
    host.read_reg(msp_pkg::ADDR_CONFIG, rd);
    chk("cfg", msp_pkg::CONFIG_RESET, rd);
    host.write_reg(msp_pkg::ADDR_CONFIG, 8'h5a, 8);
    host.write_reg(msp_pkg::ADDR_CONFIG, 8'ha5, 4);
    host.shift({1'b1, msp_pkg::ADDR_CONFIG}, 8, rd);
    host.shift(8'hc3, 8, rd);
    host.read_reg(msp_pkg::ADDR_CONFIG, rd);
    chk("cfg", 8'h5a, rd);
    host.read_reg(7'h30, rd);
    chk("unmapped", 8'h00, rd);
  endtask
  task automatic t_motion();
    nav(8'h05, 8'h03);
    chk("pin", 8'h00, {7'h00, motionPendingN});
    host.read_reg(msp_pkg::ADDR_DELTA_Y, rd);
    chk("dy", 8'h03, rd);
    chk("pin", 8'h00, {7'h00, motionPendingN});
    host.read_reg(msp_pkg::ADDR_DELTA_X, rd);
    chk("dx", 8'h05, rd);
    chk("pin", 8'h01, {7'h00, motionPendingN});
  endtask
  task automatic t_led();
    int n;
    n = 0;
    while (imageRequest !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
    n = 0;
    while (illum_led_drive === 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk("led", msp_pkg::LED_PULSE_CYCLES, 8'(n));
  endtask
  task automatic t_burst();
    logic [55:0] e;
    e = {8'h80, 8'h22, 8'h11, 8'h33, 8'h44, 8'h55, 8'h66};
    sq = 8'h33;
    sh = 16'h4455;
    mp = 8'h66;
    nav(8'h11, 8'h22);
    host.burst(bd);
    host.shift({1'b1, msp_pkg::ADDR_CONFIG}, 8, rd);
    host.shift(8'hc3, 8, rd);
    host.frame_close(msp_pkg::BURST_EXIT_GAP_NS);
    for (int i = 0; i < 7; i++) begin
      chk("burst", e[55 - 8 * i -: 8], bd[55 - 8 * i -: 8]);
    end
    chk("pin", 8'h01, {7'h00, motionPendingN});
    host.read_reg(msp_pkg::ADDR_CONFIG, rd);
    chk("cfg", 8'h5a, rd);
  endtask
  task automatic t_doze();
    int n;
    int e;
    nav(8'h01, 8'h00);
    for (int lv = 1; lv < 4; lv++) begin
      n = 0;
      e = lv == 1 ? D1 : lv == 2 ? D2 : D3;
      while (dozeLevel !== 2'(lv) && n < 6000) begin
        tick();
        n++;
      end
      numChecks++;
      if (n < e - 8 || n > e + 8) begin
        nFail++;
        $display("mismatch dwell expected %0d seen %0d", e, n);
      end
    end
    nav(8'h00, 8'h01);
    tick();
    chk("doze", 8'h00, {6'h00, dozeLevel});
    host.write_reg(msp_pkg::ADDR_MOTION, 8'h00, 8);
    chk("pin", 8'h01, {7'h00, motionPendingN});
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    tick();
    t_config();
    t_motion();
    t_led();
    t_burst();
    t_doze();
    stopTest();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    nFail++;
    $display("mismatch watchdog expected done seen timeout");
    stopTest();
  end
endmodule
